// ---- include/fcc_cfg.svh ----
// flash command controller: offsets, fields, resets and timing counts
// assumes a 32-bit apb slave with byte addresses of eight bits
`ifndef FCC_CFG_SVH
`define FCC_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FCC_AW          8
`define FCC_OFF_CLKDIV  8'h00
`define FCC_OFF_CONFIG  8'h04
`define FCC_OFF_PROT    8'h08
`define FCC_OFF_STATUS  8'h0C
`define FCC_OFF_CMD     8'h10
`define FCC_OFF_ADDR    8'h14
`define FCC_OFF_DATA    8'h18
`define FCC_OFF_ARRAY   8'h1C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FCC_DIV_LOADED  7
`define FCC_DIV_PRE8    6
`define FCC_CFG_CBEIE   7
`define FCC_CFG_CCIE    6
`define FCC_PROT_HPD    7
`define FCC_PROT_OPEN   5
`define FCC_ST_BUFFER_EMPTY_FLAG    7
`define FCC_ST_COMMAND_COMPLETE_FLAG     6
`define FCC_ST_PROTECTION_VIOLATION_FLAG    5
`define FCC_ST_ACCESS_ERROR_FLAG   4
`define FCC_ST_BLANK    2
`define FCC_ARR_ADDR_LSB 16

// ----------------------------------------------------------------
// commands, geometry, reset values
// ----------------------------------------------------------------
`define FCC_CMD_VERIFY  8'h05
`define FCC_CMD_PROG    8'h20
`define FCC_CMD_SECT    8'h40
`define FCC_CMD_MASS    8'h41
`define FCC_ABITS       14
`define FCC_HIGH_BASE   14'h3000
`define FCC_ROW_LSB     6
`define FCC_ERASED      16'hFFFF
`define FCC_ARRAY_WORDS 8192
`define FCC_PRE_LAST    3'h7
`define FCC_RST_PRDATA  32'h0000_0000

// ----------------------------------------------------------------
// timing counts in timing-clock ticks
// ----------------------------------------------------------------
`define FCC_CNT_W       16
`define FCC_RAMP_TICKS  4
`define FCC_PROG_TICKS  6
`define FCC_SECT_TICKS  4000
`define FCC_MASS_TICKS  20000

`endif

// ---- include/fcc_pkg.sv ----
// flash command controller: state types
// assumes fcc_cfg.svh is on the include path
`include "fcc_cfg.svh"

package fcc_pkg;

    // ------------------------------------------------------------
    // executor states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        EX_IDLE = 4'b0001,
        EX_RAMP = 4'b0010,
        EX_RUN  = 4'b0100,
        EX_VER  = 4'b1000
    } fcc_ex_e;

    typedef logic [`FCC_ABITS-1:0] fcc_addr_t;

    // ------------------------------------------------------------
    // whole module state
    // ------------------------------------------------------------
    typedef struct packed {
        fcc_ex_e               ex;
        logic                  ld;
        logic                  pre8;
        logic [5:0]            divide_field;
        logic [2:0]            pcnt;
        logic [5:0]            dcnt;
        logic                  tick;
        logic                  cbeie;
        logic                  ccie;
        logic                  hpd;
        logic                  popen;
        logic                  command_complete_flag;
        logic                  protection_violation_flag;
        logic                  access_error_flag;
        logic                  blank;
        logic [1:0]            seq;
        fcc_addr_t             b_addr;
        logic [15:0]           b_data;
        logic [7:0]            b_cmd;
        logic                  b_val;
        fcc_addr_t             a_addr;
        logic [15:0]           a_data;
        logic [7:0]            a_cmd;
        logic [`FCC_CNT_W-1:0] cnt;
        logic                  hv;
        logic                  prog;
        logic                  ers;
        logic                  mass;
        logic [31:0]           prdata;
    } fcc_state_s;

endpackage

// ---- rtl/fcc_top.sv ----
// flash command controller: apb registers, command pipeline, executor
// assumes an apb master on pclk and a flash array answering reads at once
//
// Function
// - command, address and data sit in a buffer plus an active stage
// - writing the divider register sets divider_loaded; reset clears it
// - launch with divider never loaded raises access error, nothing runs
// - every operation length is counted in timing-clock ticks
// - a new sequence while buffer is full overwrites the buffered command
// - register reads never disturb a command sequence
// - step one captures address and data into the buffer registers
// - launch clears the command-complete flag
// - buffer-empty sets again once the buffer moves to the active stage
// - buffered command waits; complete flag sets only when all are done
// - buffer-empty and complete raise interrupts when enabled
// - command 05 checks the array and sets blank if all erased
// - verify ignores address and data, stops at first unerased word
// - command 20 programs the captured word at the captured address
// - program or erase in a protected area sets protection flag, no launch
// - command 40 erases the 512-byte sector holding the address
// - command 41 erases everything, only with both protect-disable bits set
// - high voltage stays on between programs in the same row
// - access error clears only by writing one; it blocks launches
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fcc_cfg.svh"

module fcc_top
    import fcc_pkg::*;
#(
    parameter int RAMP_TICKS   = `FCC_RAMP_TICKS,
    parameter int PROG_TICKS   = `FCC_PROG_TICKS,
    parameter int SECT_TICKS   = `FCC_SECT_TICKS,
    parameter int MASS_TICKS   = `FCC_MASS_TICKS,
    parameter int VERIFY_WORDS = `FCC_ARRAY_WORDS
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [`FCC_AW-1:0] paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // flash array
    output logic      [12:0]      arr_addr,
    output logic      [15:0]      arr_wdata,
    input  wire logic [15:0]      arr_rdata,
    output logic                  arr_hv,
    output logic                  arr_prog,
    output logic                  arr_erase,
    output logic                  arr_erase_all,
    // interrupt requests
    output logic                  irq_buffer_empty,
    output logic                  irq_complete
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic fcc_hit(input logic [`FCC_AW-1:0] a);
        return a inside {`FCC_OFF_CLKDIV, `FCC_OFF_CONFIG, `FCC_OFF_PROT,
                         `FCC_OFF_STATUS, `FCC_OFF_CMD, `FCC_OFF_ADDR,
                         `FCC_OFF_DATA, `FCC_OFF_ARRAY};
    endfunction

    function automatic logic fcc_prot(input fcc_addr_t a, input logic hpd,
                                      input logic popen);
        return (a >= `FCC_HIGH_BASE) ? !hpd : !popen;
    endfunction

    function automatic logic [`FCC_CNT_W-1:0] fcc_last(input int t);
        return `FCC_CNT_W'(t - 1);
    endfunction

    localparam fcc_state_s FCC_RST = '{ex: EX_IDLE, default: '0};

    fcc_state_s s_r;
    fcc_state_s s_nxt;
    logic       wr;
    logic       launch_ok;
    logic       keep_hv;
    logic       buffer_empty_flag;
    logic       locked;
    logic [7:0] wcmd;
    logic [`FCC_CNT_W-1:0] run_last;

    assign buffer_empty_flag  = !s_r.b_val;
    assign locked = s_r.access_error_flag | s_r.protection_violation_flag;
    assign wr     = psel & penable & pwrite & fcc_hit(paddr);
    assign wcmd   = pwdata[7:0];

    // ----------------------------------------------------------------
    // apb answers: no wait states, data captured in the setup cycle
    // ----------------------------------------------------------------
    assign pready           = 1'b1;
    assign pslverr          = psel & penable & !fcc_hit(paddr);
    assign prdata           = s_r.prdata;
    assign arr_addr         = s_r.a_addr[`FCC_ABITS-1:1];
    assign arr_wdata        = s_r.a_data;
    assign arr_hv           = s_r.hv;
    assign arr_prog         = s_r.prog;
    assign arr_erase        = s_r.ers;
    assign arr_erase_all    = s_r.mass;
    assign irq_buffer_empty = s_r.cbeie & buffer_empty_flag;
    assign irq_complete     = s_r.ccie & s_r.command_complete_flag;

    assign run_last = (s_r.a_cmd == `FCC_CMD_PROG) ? fcc_last(PROG_TICKS) :
                      (s_r.a_cmd == `FCC_CMD_SECT) ? fcc_last(SECT_TICKS) :
                                                     fcc_last(MASS_TICKS);
    assign keep_hv  = (s_r.a_cmd == `FCC_CMD_PROG) && s_r.b_val
                      && (s_r.b_cmd == `FCC_CMD_PROG)
                      && (s_r.b_addr[`FCC_ABITS-1:`FCC_ROW_LSB]
                          == s_r.a_addr[`FCC_ABITS-1:`FCC_ROW_LSB]);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt     = s_r;
        launch_ok = 1'b0;
        s_nxt.tick = 1'b0;

        // timing clock enable
        if (s_r.ld) begin
            s_nxt.pcnt = s_r.pre8 ? s_r.pcnt + 3'h1 : 3'h0;
            if (!s_r.pre8 || s_r.pcnt == `FCC_PRE_LAST) begin
                if (s_r.dcnt == s_r.divide_field) begin
                    s_nxt.dcnt = 6'h0;
                    s_nxt.tick = 1'b1;
                end else begin
                    s_nxt.dcnt = s_r.dcnt + 6'h1;
                end
            end
        end

        // read data, no side effects
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `FCC_OFF_CLKDIV: s_nxt.prdata = {24'h0, s_r.ld, s_r.pre8, s_r.divide_field};
                `FCC_OFF_CONFIG: s_nxt.prdata = {24'h0, s_r.cbeie, s_r.ccie, 6'h0};
                `FCC_OFF_PROT:   s_nxt.prdata = {24'h0, s_r.hpd, 1'b0, s_r.popen, 5'h0};
                `FCC_OFF_STATUS: s_nxt.prdata = {24'h0, buffer_empty_flag, s_r.command_complete_flag, s_r.protection_violation_flag,
                                                 s_r.access_error_flag, 1'b0, s_r.blank, 2'h0};
                `FCC_OFF_CMD:    s_nxt.prdata = {24'h0, s_r.b_cmd};
                `FCC_OFF_ADDR:   s_nxt.prdata = {18'h0, s_r.b_addr};
                `FCC_OFF_DATA:   s_nxt.prdata = {16'h0, s_r.b_data};
                default:         s_nxt.prdata = `FCC_RST_PRDATA;
            endcase
        end

        // register writes and the command write sequence
        if (wr) begin
            case (paddr)
                `FCC_OFF_CLKDIV: begin
                    s_nxt.ld   = 1'b1;
                    s_nxt.pre8 = pwdata[`FCC_DIV_PRE8];
                    s_nxt.divide_field = pwdata[5:0];
                end
                `FCC_OFF_CONFIG: begin
                    s_nxt.cbeie = pwdata[`FCC_CFG_CBEIE];
                    s_nxt.ccie  = pwdata[`FCC_CFG_CCIE];
                end
                `FCC_OFF_PROT: begin
                    s_nxt.hpd   = pwdata[`FCC_PROT_HPD];
                    s_nxt.popen = pwdata[`FCC_PROT_OPEN];
                end
                `FCC_OFF_STATUS: begin
                    if (pwdata[`FCC_ST_ACCESS_ERROR_FLAG])
                        s_nxt.access_error_flag = 1'b0;
                    if (pwdata[`FCC_ST_PROTECTION_VIOLATION_FLAG])
                        s_nxt.protection_violation_flag = 1'b0;
                    if (s_r.seq == 2'd2 && pwdata[`FCC_ST_BUFFER_EMPTY_FLAG]) begin
                        s_nxt.seq = 2'd0;
                        if (!s_r.ld) begin
                            s_nxt.access_error_flag = 1'b1;
                        end else if (locked) begin
                            s_nxt.seq = 2'd0;
                        end else if ((s_r.b_cmd == `FCC_CMD_MASS) ?
                                     !(s_r.hpd && s_r.popen) :
                                     (s_r.b_cmd != `FCC_CMD_VERIFY &&
                                      fcc_prot(s_r.b_addr, s_r.hpd, s_r.popen))) begin
                            s_nxt.protection_violation_flag = 1'b1;
                        end else begin
                            launch_ok   = 1'b1;
                            s_nxt.b_val = 1'b1;
                            s_nxt.command_complete_flag  = 1'b0;
                            s_nxt.blank = 1'b0;
                        end
                    end else if (s_r.seq != 2'd0) begin
                        s_nxt.access_error_flag = 1'b1;
                        s_nxt.seq    = 2'd0;
                    end
                end
                `FCC_OFF_CMD: begin
                    if (s_r.seq == 2'd1 && wcmd inside {`FCC_CMD_VERIFY, `FCC_CMD_PROG,
                                                        `FCC_CMD_SECT, `FCC_CMD_MASS}) begin
                        s_nxt.b_cmd = wcmd;
                        s_nxt.seq   = 2'd2;
                    end else begin
                        s_nxt.access_error_flag = 1'b1;
                        s_nxt.seq    = 2'd0;
                    end
                end
                `FCC_OFF_ARRAY: begin
                    if (!s_r.ld || s_r.seq != 2'd0 || pwdata[`FCC_ARR_ADDR_LSB]) begin
                        s_nxt.access_error_flag = 1'b1;
                        s_nxt.seq    = 2'd0;
                    end else if (!locked) begin
                        s_nxt.b_addr = pwdata[`FCC_ARR_ADDR_LSB +: `FCC_ABITS];
                        s_nxt.b_data = pwdata[15:0];
                        s_nxt.b_val  = 1'b0;
                        s_nxt.seq    = 2'd1;
                    end
                end
                default: begin
                    if (s_r.seq != 2'd0) begin
                        s_nxt.access_error_flag = 1'b1;
                        s_nxt.seq    = 2'd0;
                    end
                end
            endcase
        end

        // executor
        case (s_r.ex)
            EX_IDLE: begin
                if (s_r.b_val) begin
                    s_nxt.b_val  = 1'b0;
                    s_nxt.a_addr = s_r.b_addr;
                    s_nxt.a_data = s_r.b_data;
                    s_nxt.a_cmd  = s_r.b_cmd;
                    s_nxt.cnt    = '0;
                    if (s_r.b_cmd == `FCC_CMD_VERIFY) begin
                        s_nxt.ex     = EX_VER;
                        s_nxt.a_addr = '0;
                    end else if (s_r.hv) begin
                        s_nxt.ex   = EX_RUN;
                        s_nxt.prog = 1'b1;
                    end else begin
                        s_nxt.ex = EX_RAMP;
                        s_nxt.hv = 1'b1;
                    end
                end else begin
                    s_nxt.hv = 1'b0;
                end
            end
            EX_RAMP: begin
                if (s_r.tick) begin
                    s_nxt.cnt = s_r.cnt + 1'b1;
                    if (s_r.cnt == fcc_last(RAMP_TICKS)) begin
                        s_nxt.ex   = EX_RUN;
                        s_nxt.cnt  = '0;
                        s_nxt.prog = (s_r.a_cmd == `FCC_CMD_PROG);
                        s_nxt.ers  = (s_r.a_cmd == `FCC_CMD_SECT);
                        s_nxt.mass = (s_r.a_cmd == `FCC_CMD_MASS);
                    end
                end
            end
            EX_RUN: begin
                if (s_r.tick) begin
                    s_nxt.cnt = s_r.cnt + 1'b1;
                    if (s_r.cnt == run_last) begin
                        s_nxt.ex   = EX_IDLE;
                        s_nxt.prog = 1'b0;
                        s_nxt.ers  = 1'b0;
                        s_nxt.mass = 1'b0;
                        s_nxt.hv   = keep_hv;
                        if (!s_nxt.b_val)
                            s_nxt.command_complete_flag = 1'b1;
                    end
                end
            end
            EX_VER: begin
                if (s_r.tick) begin
                    if (arr_rdata != `FCC_ERASED) begin
                        s_nxt.ex = EX_IDLE;
                    end else if (s_r.a_addr[`FCC_ABITS-1:1] == 13'(VERIFY_WORDS - 1)) begin
                        s_nxt.ex    = EX_IDLE;
                        s_nxt.blank = 1'b1;
                    end else begin
                        s_nxt.a_addr = s_r.a_addr + `FCC_ABITS'(2);
                    end
                    if (s_nxt.ex == EX_IDLE && !s_nxt.b_val)
                        s_nxt.command_complete_flag = 1'b1;
                end
            end
            default: begin
                s_nxt.ex = EX_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            s_r <= FCC_RST;
        else
            s_r <= s_nxt;
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_launch;
        launch_ok && s_r.ex == EX_IDLE && !s_r.b_val;
    endsequence

    sequence s_run_end;
        s_r.ex == EX_RUN && s_r.tick && s_r.cnt == run_last;
    endsequence

    a_div_loaded: assert property (wr && paddr == `FCC_OFF_CLKDIV |=> s_r.ld)
        else $error("divider write did not set loaded bit");
    a_no_exec_unload: assert property (!s_r.ld |-> s_r.ex == EX_IDLE && !s_r.b_val)
        else $error("command ran with divider unloaded");
    a_launch_clears_cc: assert property (s_launch |=> !s_r.command_complete_flag && !buffer_empty_flag)
        else $error("launch left complete flag set");
    a_buffer_refills: assert property (s_launch |-> ##2 buffer_empty_flag && s_r.ex != EX_IDLE)
        else $error("buffer-empty not back two cycles after launch");
    a_cc_waits_buffer: assert property (s_r.b_val |-> !s_r.command_complete_flag)
        else $error("complete flag set with a buffered command");
    a_access_error_flag_sticky: assert property (s_r.access_error_flag && !(wr && paddr == `FCC_OFF_STATUS
                                      && pwdata[`FCC_ST_ACCESS_ERROR_FLAG]) |=> s_r.access_error_flag)
        else $error("access error cleared without a write of one");
    a_verify_stops: assert property (s_r.ex == EX_VER && s_r.tick
                                     && arr_rdata != `FCC_ERASED
                                     |=> s_r.ex == EX_IDLE && !s_r.blank)
        else $error("verify went on past an unerased word");
    a_hv_row_keep: assert property (s_run_end ##0 keep_hv |=> s_r.hv ##1 s_r.prog)
        else $error("high voltage dropped between same-row programs");
    a_protection_violation_flag_blocks: assert property (s_r.protection_violation_flag && !(wr && paddr == `FCC_OFF_STATUS)
                                     |=> !s_r.b_val)
        else $error("command buffered while protection flag set");
    a_irq_complete: assert property ($rose(s_r.command_complete_flag) && s_r.ccie |-> irq_complete)
        else $error("complete interrupt missing");

    // ----------------------------------------------------------------
    // timebase, executor and protection checks
    // ----------------------------------------------------------------
    sequence s_ver_last;
        s_r.ex == EX_VER && s_r.tick && arr_rdata == `FCC_ERASED
        && s_r.a_addr[`FCC_ABITS-1:1] == 13'(VERIFY_WORDS - 1);
    endsequence

    sequence s_protection_violation_flag_kept;
        s_r.protection_violation_flag && !(wr && paddr == `FCC_OFF_STATUS && pwdata[`FCC_ST_PROTECTION_VIOLATION_FLAG]);
    endsequence

    a_verify_blank: assert property (s_ver_last |=> s_r.blank && s_r.ex == EX_IDLE)
        else $error("verify of an erased array left blank clear");
    a_protection_violation_flag_sticky: assert property (s_protection_violation_flag_kept |=> s_r.protection_violation_flag)
        else $error("protection flag cleared without a write of one");
    a_prescale_tick: assert property (s_r.tick && s_r.pre8 |-> s_r.pcnt == 3'h0)
        else $error("timing tick outside the prescale wrap");
    a_loads_at_once: assert property (s_r.ex == EX_IDLE && s_r.b_val
                                      |=> s_r.ex != EX_IDLE)
        else $error("idle executor did not take the buffered command");
    a_erase_onehot: assert property ($onehot0({s_r.prog, s_r.ers, s_r.mass}))
        else $error("more than one array operation at once");

endmodule

`default_nettype wire

// ---- test/fcc_array_model.sv ----
// flash array model: word memory read at once, program, sector and mass erase
// assumes the controller holds the array outputs as levels for whole operations
`timescale 1ns/1ps
`default_nettype none

module fcc_array_model (
    // clock
    input  wire logic        pclk,
    // array side of the controller
    input  wire logic [12:0] arr_addr,
    input  wire logic [15:0] arr_wdata,
    output logic      [15:0] arr_rdata,
    input  wire logic        arr_hv,
    input  wire logic        arr_prog,
    input  wire logic        arr_erase,
    input  wire logic        arr_erase_all
);
    logic [15:0] mem [0:8191];
    logic        prog_d;
    logic        ers_d;
    logic        all_d;

    initial begin
        foreach (mem[i]) mem[i] = 16'hFFFF;
        prog_d = 1'b0;
        ers_d  = 1'b0;
        all_d  = 1'b0;
    end

    assign arr_rdata = mem[arr_addr];

    // ------------------------------------------------------------
    // array actions on the rising edge of each level
    // ------------------------------------------------------------
    always @(posedge pclk) begin
        prog_d <= arr_prog;
        ers_d  <= arr_erase;
        all_d  <= arr_erase_all;
        // programming without high voltage leaves the cell alone
        if (arr_prog && !prog_d && arr_hv) begin
            mem[arr_addr] <= mem[arr_addr] & arr_wdata;
        end
        if (arr_erase && !ers_d) begin
            for (int i = 0; i < 256; i++) mem[{arr_addr[12:8], i[7:0]}] <= 16'hFFFF;
        end
        if (arr_erase_all && !all_d) begin
            foreach (mem[i]) mem[i] <= 16'hFFFF;
        end
    end
endmodule
`default_nettype wire

// ---- test/fcc_tb_top.sv ----
// flash command controller bench: apb register tasks and command scenarios
// assumes fcc_cfg.svh on the include path and the array model beside the dut
`timescale 1ns/1ps
`default_nettype none
`include "fcc_cfg.svh"

module fcc_tb_top;
    import fcc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [12:0] arr_addr;
    logic [15:0] arr_wdata, arr_rdata;
    logic        arr_hv, arr_prog, arr_erase, arr_erase_all, irq_be, irq_cc;
    int          mismatches, checks, cyc, t0, t1;

    fcc_top #(.RAMP_TICKS(4), .PROG_TICKS(6), .SECT_TICKS(8), .MASS_TICKS(10),
        .VERIFY_WORDS(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .arr_addr(arr_addr),
        .arr_wdata(arr_wdata), .arr_rdata(arr_rdata), .arr_hv(arr_hv),
        .arr_prog(arr_prog), .arr_erase(arr_erase), .arr_erase_all(arr_erase_all),
        .irq_buffer_empty(irq_be), .irq_complete(irq_cc));
    fcc_array_model u_arr (.pclk(pclk), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
        .arr_rdata(arr_rdata), .arr_hv(arr_hv), .arr_prog(arr_prog),
        .arr_erase(arr_erase), .arr_erase_all(arr_erase_all));

    always #4 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task final_report;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask

    // address and data, command, launch, nothing in between
    task cmd(input logic [13:0] a, input logic [15:0] d, input logic [7:0] c);
        apb(1'b1, `FCC_OFF_ARRAY, {2'b00, a, d});
        apb(1'b1, `FCC_OFF_CMD, {24'h0, c});
        apb(1'b1, `FCC_OFF_STATUS, 32'h80);
    endtask

    task wait_done;
        int n;
        n = 0;
        do begin
            apb(1'b0, `FCC_OFF_STATUS, 32'h0);
            n++;
        end while (rd[6] !== 1'b1 && n < 3000);
        check({31'h0, rd[6]}, 32'h1);
    endtask

    task st(input logic [31:0] exp);
        apb(1'b0, `FCC_OFF_STATUS, 32'h0);
        check(rd, exp);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
        pwdata = 32'h0; mismatches = 0; checks = 0; cyc = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `FCC_OFF_CLKDIV, 32'h0); check(rd, 32'h0);
        st(32'h80);
        cmd(14'h0010, 16'h1234, 8'h20); st(32'h90);
        apb(1'b1, `FCC_OFF_STATUS, 32'h00); st(32'h90);
        apb(1'b1, `FCC_OFF_STATUS, 32'h10); st(32'h80);
        apb(1'b1, `FCC_OFF_CLKDIV, 32'h00);
        apb(1'b0, `FCC_OFF_CLKDIV, 32'h0); check(rd, 32'h80);
        cmd(14'h0010, 16'h1234, 8'h20); st(32'hA0);
        check(u_arr.mem[8], 16'hFFFF);
        apb(1'b1, `FCC_OFF_STATUS, 32'h20);
        apb(1'b1, `FCC_OFF_PROT, 32'h20);
        apb(1'b0, `FCC_OFF_PROT, 32'h0); check(rd, 32'h20);
        t0 = cyc;
        cmd(14'h0010, 16'h1234, 8'h20); st(32'h80);
        wait_done; t0 = cyc - t0;
        check(u_arr.mem[8], 16'h1234);
        apb(1'b1, `FCC_OFF_CONFIG, 32'hC0);
        check({30'h0, irq_be, irq_cc}, 32'h3);
        apb(1'b1, `FCC_OFF_CONFIG, 32'h40);
        check({30'h0, irq_be, irq_cc}, 32'h1);
        cmd(14'h0000, 16'h0000, 8'h05); wait_done; st(32'hC0);
        cmd(14'h0000, 16'h0000, 8'h40); wait_done;
        check(u_arr.mem[8], 16'hFFFF);
        cmd(14'h0010, 16'h5555, 8'h05); wait_done; st(32'hC4);
        apb(1'b1, `FCC_OFF_CLKDIV, 32'h40);
        apb(1'b0, `FCC_OFF_CLKDIV, 32'h0); check(rd, 32'hC0);
        t1 = cyc;
        apb(1'b1, `FCC_OFF_ARRAY, {18'h0030, 16'h00C3});
        st(32'hC4);
        apb(1'b1, `FCC_OFF_CMD, 32'h20);
        apb(1'b1, `FCC_OFF_STATUS, 32'h80);
        wait_done; t1 = cyc - t1;
        check(u_arr.mem[24], 16'h00C3);
        check({31'h0, t1 > t0}, 32'h1);
        apb(1'b1, `FCC_OFF_CLKDIV, 32'h3F);
        cmd(14'h0200, 16'h0000, 8'h40);
        cmd(14'h0040, 16'h0A0A, 8'h20); st(32'h00);
        cmd(14'h0042, 16'h0B0B, 8'h20); wait_done;
        check(u_arr.mem[32], 16'hFFFF);
        check(u_arr.mem[33], 16'h0B0B);
        apb(1'b1, `FCC_OFF_CLKDIV, 32'h00);
        cmd(14'h0000, 16'h0000, 8'h41); st(32'hE0);
        apb(1'b1, `FCC_OFF_STATUS, 32'h20);
        apb(1'b1, `FCC_OFF_PROT, 32'hA0);
        cmd(14'h0000, 16'h0000, 8'h41); wait_done;
        check(u_arr.mem[33], 16'hFFFF);
        cmd(14'h0000, 16'h0000, 8'h07); st(32'hD0);
        cmd(14'h0050, 16'h0000, 8'h20); st(32'hD0);
        check(u_arr.mem[40], 16'hFFFF);
        apb(1'b0, 8'h20, 32'h0); check({31'h0, err}, 32'h1);
        final_report;
    end

    initial begin
        repeat (60000) @(posedge pclk);
        mismatches++;
        final_report;
    end
endmodule
`default_nettype wire
